/* File: inc/ccr_params.svh */
// constants for the core register file: sfr addresses, reset values, flag bit positions
`ifndef CCR_PARAMS_SVH
`define CCR_PARAMS_SVH
`define CCR_ADDR_STACK 8'h81
`define CCR_ADDR_PTR_LO 8'h82
`define CCR_ADDR_PTR_HI 8'h83
`define CCR_ADDR_STATUS 8'hd0
`define CCR_ADDR_ARITH 8'he0
`define CCR_ADDR_SECOND 8'hf0
`define CCR_RST_STACK 8'h07
`define CCR_RST_ZERO 8'h00
`define CCR_BIT_CY 7
`define CCR_BIT_AC 6
`define CCR_BIT_F0 5
`define CCR_BIT_RS1 4
`define CCR_BIT_RS0 3
`define CCR_BIT_OV 2
`define CCR_BIT_F1 1
`define CCR_BIT_P 0
`define CCR_BYTE_MAX 9'h0ff
`define CCR_BCD_LIMIT 9'h09f
`endif

/* File: inc/ccr_pkg.sv */
// types shared by the core register file modules
package ccr_pkg;
  typedef enum logic [3:0] {
    CCR_OP_NONE = 4'b0000,
    CCR_OP_ADD = 4'b0001,
    CCR_OP_SUM_CARRY_OP = 4'b0010,
    CCR_OP_BORROW_SUB_OP = 4'b0011,
    CCR_OP_MUL = 4'b0100,
    CCR_OP_DIV = 4'b0101,
    CCR_OP_DA = 4'b0110,
    CCR_OP_COMPARE_JUMP_OP = 4'b0111,
    CCR_OP_PUSH = 4'b1000,
    CCR_OP_POP = 4'b1001
  } ccr_op_type;
endpackage : ccr_pkg

/* File: hw/ccr_flag_calc.sv */
// flag and result computation for arithmetic operations
`timescale 1ns/1ps
`include "ccr_params.svh"
module ccr_flag_calc
  import ccr_pkg::*;
(
  // operation and operands
  input wire ccr_op_type op_i,
  input wire logic [7:0] a_i,
  input wire logic [7:0] b_i,
  input wire logic cy_i,
  // results
  output logic [7:0] res_a_o,
  output logic [7:0] res_b_o,
  output logic cy_o,
  output logic ac_o,
  output logic ov_o,
  output logic upd_cy_o,
  output logic upd_ac_o,
  output logic upd_ov_o,
  output logic upd_a_o,
  output logic upd_b_o
);
  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] low7;
  logic [15:0] prod;
  logic [8:0] adj;
  logic cin;
  // one combinational evaluation per operation
  always_comb begin
    sum = 9'h000;
    nib = 5'h00;
    low7 = 8'h00;
    prod = 16'h0000;
    adj = 9'h000;
    cin = 1'b0;
    res_a_o = a_i;
    res_b_o = b_i;
    cy_o = cy_i;
    ac_o = 1'b0;
    ov_o = 1'b0;
    upd_cy_o = 1'b0;
    upd_ac_o = 1'b0;
    upd_ov_o = 1'b0;
    upd_a_o = 1'b0;
    upd_b_o = 1'b0;
    unique case (op_i)
      CCR_OP_ADD, CCR_OP_SUM_CARRY_OP: begin
        cin = (op_i == CCR_OP_SUM_CARRY_OP) ? cy_i : 1'b0;
        sum = {1'b0, a_i} + {1'b0, b_i} + {8'h00, cin};
        nib = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, cin};
        low7 = {1'b0, a_i[6:0]} + {1'b0, b_i[6:0]} + {7'h00, cin};
        res_a_o = sum[7:0];
        cy_o = sum[8]; // RULE6
        ac_o = nib[4]; // RULE10
        ov_o = sum[8] ^ low7[7]; // RULE14
        {upd_a_o, upd_cy_o, upd_ac_o, upd_ov_o} = 4'hf;
      end
      CCR_OP_BORROW_SUB_OP: begin
        sum = {1'b0, a_i} - {1'b0, b_i} - {8'h00, cy_i};
        nib = {1'b0, a_i[3:0]} - {1'b0, b_i[3:0]} - {4'h0, cy_i};
        low7 = {1'b0, a_i[6:0]} - {1'b0, b_i[6:0]} - {7'h00, cy_i};
        res_a_o = sum[7:0];
        cy_o = sum[8]; // RULE6
        ac_o = nib[4]; // RULE10
        ov_o = sum[8] ^ low7[7]; // RULE14
        {upd_a_o, upd_cy_o, upd_ac_o, upd_ov_o} = 4'hf;
      end
      CCR_OP_MUL: begin
        prod = a_i * b_i;
        res_a_o = prod[7:0];
        res_b_o = prod[15:8];
        cy_o = 1'b0; // RULE7
        ov_o = (prod[15:8] != 8'h00); // RULE15
        {upd_a_o, upd_b_o, upd_cy_o, upd_ov_o} = 4'hf;
      end
      CCR_OP_DIV: begin
        // divide by zero leaves results undefined; we keep the operands
        if (b_i != 8'h00) begin
          res_a_o = a_i / b_i;
          res_b_o = a_i % b_i;
        end
        cy_o = 1'b0; // RULE7
        ov_o = (b_i == 8'h00);
        {upd_a_o, upd_b_o, upd_cy_o, upd_ov_o} = 4'hf;
      end
      CCR_OP_DA: begin
        adj = {1'b0, a_i};
        if ((adj[3:0] > 4'h9) || ac_i_dummy(1'b0)) begin
          adj = adj + 9'h006;
        end
        if ((adj > `CCR_BCD_LIMIT) || cy_i) begin
          adj = adj + 9'h060;
        end
        res_a_o = adj[7:0];
        cy_o = adj[8] | cy_i; // RULE8
        {upd_a_o, upd_cy_o} = 2'b11;
      end
      CCR_OP_COMPARE_JUMP_OP: begin
        cy_o = (a_i < b_i); // RULE9
        upd_cy_o = 1'b1;
      end
      default: begin
      end
    endcase
  end
  // nibble carry input for decimal adjust is tied to zero; only a low nibble above 9 adds 06h
  function automatic logic ac_i_dummy(input logic v);
    ac_i_dummy = v;
  endfunction : ac_i_dummy
endmodule : ccr_flag_calc

/* File: hw/ccr_bank_map.sv */
// maps a working register number to its internal ram address
`timescale 1ns/1ps
module ccr_bank_map (
  // bank and register select
  input wire logic [1:0] bank_i,
  input wire logic [2:0] reg_i,
  // ram address
  output logic [7:0] addr_o
);
  // bank n places r0..r7 at 8*n .. 8*n+7
  assign addr_o = {3'b000, bank_i, reg_i}; // RULE18
endmodule : ccr_bank_map

/* File: hw/ccr_core_regs.sv */
// core architectural registers and status flags of the cpu
// How it works
// RULE1 - accumulator 8-bit rw, resets to zero
// RULE2 - second operand register, zero reset, mul/div
// RULE3 - stack push increments index, then writes
// RULE4 - stack index resets to 07h
// RULE5 - pointer word is high byte over low
// RULE6 - carry shows add carry or subtract borrow
// RULE7 - multiply and divide clear carry
// RULE8 - decimal adjust sets carry past 100
// RULE9 - compare sets carry when first smaller
// RULE10 - nibble carry from bit 3
// RULE11 - user flag bit 5 freely writable
// RULE12 - bank bits 4:3 choose register bank
// RULE13 - status resets zero, bit 0 read-only
// RULE14 - signed wrap: carry bit6 xor bit7
// RULE15 - multiply sets wrap when product over 255
// RULE16 - parity follows accumulator odd count
// RULE17 - status writes never change parity
// RULE18 - bank n maps to ram 8n..8n+7
`timescale 1ns/1ps
`include "ccr_params.svh"
module ccr_core_regs
  import ccr_pkg::*;
(
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  // special function register access
  input wire logic SFR_WR_I,
  input wire logic [7:0] SFR_ADDR_I,
  input wire logic [7:0] SFR_WDATA_I,
  output logic [7:0] SFR_RDATA_O,
  output logic SFR_HIT_O,
  // execution unit operation
  input wire ccr_op_type OP_I,
  input wire logic [7:0] OPERAND_I,
  // stack ram write port
  input wire logic [7:0] PUSH_DATA_I,
  output logic RAM_WR_O,
  output logic [7:0] RAM_ADDR_O,
  output logic [7:0] RAM_WDATA_O,
  // working register lookup
  input wire logic [2:0] WREG_SEL_I,
  output logic [7:0] WREG_ADDR_O,
  // register views
  output logic [7:0] MAIN_ARITH_REG_O,
  output logic [7:0] SECOND_OPERAND_REG_O,
  output logic [7:0] STACK_TOP_INDEX_O,
  output logic [15:0] DATA_POINTER_WORD_O,
  output logic [7:0] STATUS_WORD_O,
  output logic [1:0] BANK_SEL_O
);
  logic [7:0] main_arith_reg;
  logic [7:0] second_operand_reg;
  logic [7:0] stack_top_index;
  logic [7:0] pointer_low_byte;
  logic [7:0] pointer_high_byte;
  logic carry_out_flag;
  logic nibble_carry_flag;
  logic user_flag_zero;
  logic bank_select_high;
  logic bank_select_low;
  logic signed_wrap_flag;
  logic user_flag_one;
  logic parity_flag;
  logic [7:0] next_a;
  logic [7:0] next_b;
  logic next_cy;
  logic next_ac;
  logic next_ov;
  logic upd_cy;
  logic upd_ac;
  logic upd_ov;
  logic upd_a;
  logic upd_b;
  logic wr_acc;
  logic wr_b;
  logic wr_sp;
  logic wr_dpl;
  logic wr_dph;
  logic wr_psw;
  logic [7:0] next_sp;
  ////////////////////////////////////////////////////////////////////////////
  // arithmetic unit and bank decoder
  ccr_flag_calc u_calc (
    .op_i(OP_I),
    .a_i(main_arith_reg),
    .b_i((OP_I == CCR_OP_MUL || OP_I == CCR_OP_DIV) ? second_operand_reg : OPERAND_I),
    .cy_i(carry_out_flag),
    .res_a_o(next_a),
    .res_b_o(next_b),
    .cy_o(next_cy),
    .ac_o(next_ac),
    .ov_o(next_ov),
    .upd_cy_o(upd_cy),
    .upd_ac_o(upd_ac),
    .upd_ov_o(upd_ov),
    .upd_a_o(upd_a),
    .upd_b_o(upd_b)
  );
  ccr_bank_map u_bank (
    .bank_i({bank_select_high, bank_select_low}), // RULE12
    .reg_i(WREG_SEL_I),
    .addr_o(WREG_ADDR_O)
  );
  ////////////////////////////////////////////////////////////////////////////
  // address decode; execution results win over a same-cycle software write
  assign wr_acc = SFR_WR_I && (SFR_ADDR_I == `CCR_ADDR_ARITH);
  assign wr_b = SFR_WR_I && (SFR_ADDR_I == `CCR_ADDR_SECOND);
  assign wr_sp = SFR_WR_I && (SFR_ADDR_I == `CCR_ADDR_STACK);
  assign wr_dpl = SFR_WR_I && (SFR_ADDR_I == `CCR_ADDR_PTR_LO);
  assign wr_dph = SFR_WR_I && (SFR_ADDR_I == `CCR_ADDR_PTR_HI);
  assign wr_psw = SFR_WR_I && (SFR_ADDR_I == `CCR_ADDR_STATUS);
  // accumulator
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      main_arith_reg <= `CCR_RST_ZERO; // RULE1
    end else if (upd_a) begin
      main_arith_reg <= next_a;
    end else if (wr_acc) begin
      main_arith_reg <= SFR_WDATA_I; // RULE1
    end
  end
  // second operand register
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      second_operand_reg <= `CCR_RST_ZERO; // RULE2
    end else if (upd_b) begin
      second_operand_reg <= next_b; // RULE2
    end else if (wr_b) begin
      second_operand_reg <= SFR_WDATA_I;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // stack index: pre-increment on push, post-decrement on pop
  always_comb begin
    next_sp = stack_top_index;
    if (OP_I == CCR_OP_PUSH) begin
      next_sp = stack_top_index + 8'h01; // RULE3
    end else if (OP_I == CCR_OP_POP) begin
      next_sp = stack_top_index - 8'h01;
    end else if (wr_sp) begin
      next_sp = SFR_WDATA_I;
    end
  end
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      stack_top_index <= `CCR_RST_STACK; // RULE4
    end else begin
      stack_top_index <= next_sp;
    end
  end
  // stack ram write uses the incremented index in the same cycle
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      RAM_WR_O <= 1'b0;
      RAM_ADDR_O <= `CCR_RST_ZERO;
      RAM_WDATA_O <= `CCR_RST_ZERO;
    end else begin
      RAM_WR_O <= (OP_I == CCR_OP_PUSH);
      RAM_ADDR_O <= next_sp; // RULE3
      RAM_WDATA_O <= PUSH_DATA_I;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // data pointer bytes
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      pointer_low_byte <= `CCR_RST_ZERO;
      pointer_high_byte <= `CCR_RST_ZERO;
    end else begin
      if (wr_dpl) begin
        pointer_low_byte <= SFR_WDATA_I;
      end
      if (wr_dph) begin
        pointer_high_byte <= SFR_WDATA_I;
      end
    end
  end
  assign DATA_POINTER_WORD_O = {pointer_high_byte, pointer_low_byte}; // RULE5
  ////////////////////////////////////////////////////////////////////////////
  // status flags; hardware flag updates take priority over software writes
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      carry_out_flag <= 1'b0; // RULE13
      nibble_carry_flag <= 1'b0;
      signed_wrap_flag <= 1'b0;
    end else begin
      if (upd_cy) begin
        carry_out_flag <= next_cy; // RULE6
      end else if (wr_psw) begin
        carry_out_flag <= SFR_WDATA_I[`CCR_BIT_CY];
      end
      if (upd_ac) begin
        nibble_carry_flag <= next_ac; // RULE10
      end else if (wr_psw) begin
        nibble_carry_flag <= SFR_WDATA_I[`CCR_BIT_AC];
      end
      if (upd_ov) begin
        signed_wrap_flag <= next_ov; // RULE14
      end else if (wr_psw) begin
        signed_wrap_flag <= SFR_WDATA_I[`CCR_BIT_OV];
      end
    end
  end
  // software-only status bits
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      user_flag_zero <= 1'b0; // RULE13
      user_flag_one <= 1'b0;
      bank_select_high <= 1'b0;
      bank_select_low <= 1'b0;
    end else if (wr_psw) begin
      user_flag_zero <= SFR_WDATA_I[`CCR_BIT_F0]; // RULE11
      user_flag_one <= SFR_WDATA_I[`CCR_BIT_F1];
      bank_select_high <= SFR_WDATA_I[`CCR_BIT_RS1]; // RULE12
      bank_select_low <= SFR_WDATA_I[`CCR_BIT_RS0];
    end
  end
  // parity is pure logic on the accumulator, so no status write can reach it
  assign parity_flag = ^main_arith_reg; // RULE16 RULE17
  assign STATUS_WORD_O = {carry_out_flag, nibble_carry_flag, user_flag_zero,
    bank_select_high, bank_select_low, signed_wrap_flag, user_flag_one, parity_flag};
  ////////////////////////////////////////////////////////////////////////////
  // read mux; unmapped addresses read zero and drop the hit flag
  always_comb begin
    SFR_HIT_O = 1'b1;
    unique case (SFR_ADDR_I)
      `CCR_ADDR_ARITH: SFR_RDATA_O = main_arith_reg;
      `CCR_ADDR_SECOND: SFR_RDATA_O = second_operand_reg;
      `CCR_ADDR_STACK: SFR_RDATA_O = stack_top_index;
      `CCR_ADDR_PTR_LO: SFR_RDATA_O = pointer_low_byte;
      `CCR_ADDR_PTR_HI: SFR_RDATA_O = pointer_high_byte;
      `CCR_ADDR_STATUS: SFR_RDATA_O = STATUS_WORD_O;
      default: begin
        SFR_RDATA_O = `CCR_RST_ZERO;
        SFR_HIT_O = 1'b0;
      end
    endcase
  end
  assign MAIN_ARITH_REG_O = main_arith_reg;
  assign SECOND_OPERAND_REG_O = second_operand_reg;
  assign STACK_TOP_INDEX_O = stack_top_index;
  assign BANK_SEL_O = {bank_select_high, bank_select_low};
  ////////////////////////////////////////////////////////////////////////////
  // assertions
  a_acc_reset: assert property (@(posedge CLK_SYS_I) $fell(RST_I) |-> main_arith_reg == 8'h00)
    else $error("accumulator not zero after reset"); // RULE1
  a_b_reset: assert property (@(posedge CLK_SYS_I) $fell(RST_I) |-> second_operand_reg == 8'h00)
    else $error("second register not zero after reset"); // RULE2
  a_push_incr: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    OP_I == CCR_OP_PUSH |=> RAM_WR_O && RAM_ADDR_O == stack_top_index)
    else $error("push address wrong"); // RULE3
  a_sp_reset: assert property (@(posedge CLK_SYS_I) $fell(RST_I) |->
    stack_top_index == `CCR_RST_STACK)
    else $error("stack index reset wrong"); // RULE4
  a_ptr_concat: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    wr_dph |=> DATA_POINTER_WORD_O[15:8] == $past(SFR_WDATA_I))
    else $error("pointer high byte wrong"); // RULE5
  a_add_carry: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    OP_I == CCR_OP_ADD |=> carry_out_flag == ($past(main_arith_reg) + $past(OPERAND_I) > 255))
    else $error("add carry wrong"); // RULE6
  a_mul_carry: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    (OP_I == CCR_OP_MUL || OP_I == CCR_OP_DIV) |=> !carry_out_flag)
    else $error("mul/div carry not zero"); // RULE7
  a_compare_jump_op_carry: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    OP_I == CCR_OP_COMPARE_JUMP_OP |=> carry_out_flag == ($past(main_arith_reg) < $past(OPERAND_I)))
    else $error("compare carry wrong"); // RULE9
  a_mul_wrap: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    OP_I == CCR_OP_MUL |=> signed_wrap_flag == (second_operand_reg != 8'h00))
    else $error("multiply wrap wrong"); // RULE15
  a_parity_track: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    wr_acc && !upd_a |=> STATUS_WORD_O[0] == ^$past(SFR_WDATA_I))
    else $error("parity wrong"); // RULE16
  a_user_flag: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    wr_psw |=> user_flag_zero == $past(SFR_WDATA_I[`CCR_BIT_F0]))
    else $error("user flag not written"); // RULE11
  a_bank_addr: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    WREG_ADDR_O == {3'b000, BANK_SEL_O, WREG_SEL_I})
    else $error("bank address wrong"); // RULE18
  c_push: cover property (@(posedge CLK_SYS_I) disable iff (RST_I) OP_I == CCR_OP_PUSH);
  c_mul_wrap: cover property (@(posedge CLK_SYS_I) disable iff (RST_I)
    OP_I == CCR_OP_MUL ##1 signed_wrap_flag);
  c_bank3: cover property (@(posedge CLK_SYS_I) disable iff (RST_I) BANK_SEL_O == 2'b11);
endmodule : ccr_core_regs

/* File: tb/tb_cpu_core_regs_and_flags.sv */
// self-checking bench for the core register file and status flags
`timescale 1ns/1ps
`include "ccr_params.svh"
module tb_cpu_core_regs_and_flags
  import ccr_pkg::*;
();
  typedef struct {int kind; logic [15:0] exp; int due;} ccr_note_type;
  logic clk, rst, sfr_wr, sfr_hit, ram_wr;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, operand, push_data, ram_addr, ram_wdata;
  logic [7:0] wreg_addr, acc_o, b_o, sp_o, status_o;
  logic [2:0] wreg_sel;
  logic [15:0] data_pointer_word_o;
  logic [1:0] bank_o;
  ccr_op_type op;
  ccr_note_type notes[$];
  ccr_note_type n;
  logic [15:0] rq[$];
  logic [7:0] m_acc, m_b, m_sp, m_lo, m_hi;
  logic [7:1] m_psw;
  int cyc, mismatches, checks;
  string kname[9] = '{"acc", "second", "stack", "pointer", "status", "rdata", "hit", "wreg", "bank"};
  logic [7:0] addrs[7] = '{8'h81, 8'h82, 8'h83, 8'hd0, 8'he0, 8'hf0, 8'h84};
  ccr_op_type arith[6] = '{CCR_OP_ADD, CCR_OP_SUM_CARRY_OP, CCR_OP_BORROW_SUB_OP, CCR_OP_MUL, CCR_OP_DIV,
    CCR_OP_COMPARE_JUMP_OP};

  ccr_core_regs ccr_core_regs_inst (
    .CLK_SYS_I(clk), .RST_I(rst), .SFR_WR_I(sfr_wr), .SFR_ADDR_I(sfr_addr),
    .SFR_WDATA_I(sfr_wdata), .SFR_RDATA_O(sfr_rdata), .SFR_HIT_O(sfr_hit), .OP_I(op),
    .OPERAND_I(operand), .PUSH_DATA_I(push_data), .RAM_WR_O(ram_wr), .RAM_ADDR_O(ram_addr),
    .RAM_WDATA_O(ram_wdata), .WREG_SEL_I(wreg_sel), .WREG_ADDR_O(wreg_addr),
    .MAIN_ARITH_REG_O(acc_o), .SECOND_OPERAND_REG_O(b_o), .STACK_TOP_INDEX_O(sp_o),
    .DATA_POINTER_WORD_O(data_pointer_word_o), .STATUS_WORD_O(status_o), .BANK_SEL_O(bank_o));

  // 40 mhz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // compare tasks and the end of run
  task automatic cmp_reg(int k, logic [15:0] e, logic [15:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", kname[k], e, g);
    end
  endtask : cmp_reg

  task automatic cmp_ram(logic [15:0] e, logic [15:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] ram_write expected %h seen %h", e, g);
    end
  endtask : cmp_ram

  task automatic test_done;
    // a note never consumed means a result never appeared
    if (notes.size() != 0 || rq.size() != 0) mismatches++;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done

  function automatic logic [15:0] got(int k);
    case (k)
      0: return {8'h00, acc_o};
      1: return {8'h00, b_o};
      2: return {8'h00, sp_o};
      3: return data_pointer_word_o;
      4: return {8'h00, status_o};
      5: return {8'h00, sfr_rdata};
      6: return {15'h0000, sfr_hit};
      7: return {8'h00, wreg_addr};
      default: return {14'h0000, bank_o};
    endcase
  endfunction : got

  ////////////////////////////////////////////////////////////////////////////////
  // driver side: expectations are noted for the edge after the drive
  task automatic note(int k, logic [15:0] e);
    notes.push_back('{k, e, cyc + 1});
  endtask : note

  task automatic chk_all;
    note(0, {8'h00, m_acc});
    note(1, {8'h00, m_b});
    note(2, {8'h00, m_sp});
    note(3, {m_hi, m_lo});
    note(4, {8'h00, m_psw, ^m_acc});
    note(8, {14'h0000, m_psw[4:3]});
  endtask : chk_all

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge clk);
    sfr_wr = 1'b1;
    op = CCR_OP_NONE;
    sfr_addr = a;
    sfr_wdata = d;
    case (a)
      `CCR_ADDR_STACK: m_sp = d;
      `CCR_ADDR_PTR_LO: m_lo = d;
      `CCR_ADDR_PTR_HI: m_hi = d;
      `CCR_ADDR_STATUS: m_psw = d[7:1];
      `CCR_ADDR_ARITH: m_acc = d;
      `CCR_ADDR_SECOND: m_b = d;
      default: ;
    endcase
    chk_all();
  endtask : wr

  task automatic rd(logic [7:0] a);
    logic [7:0] e;
    @(negedge clk);
    sfr_wr = 1'b0;
    op = CCR_OP_NONE;
    sfr_addr = a;
    case (a)
      `CCR_ADDR_STACK: e = m_sp;
      `CCR_ADDR_PTR_LO: e = m_lo;
      `CCR_ADDR_PTR_HI: e = m_hi;
      `CCR_ADDR_STATUS: e = {m_psw, ^m_acc};
      `CCR_ADDR_ARITH: e = m_acc;
      `CCR_ADDR_SECOND: e = m_b;
      default: e = 8'h00;
    endcase
    note(5, {8'h00, e});
    note(6, {15'h0000, a != 8'h84});
  endtask : rd

  task automatic op_run(ccr_op_type o, logic [7:0] v);
    logic [8:0] s;
    logic [7:0] t;
    logic [15:0] p;
    logic cin;
    logic h;
    @(negedge clk);
    sfr_wr = 1'b0;
    op = o;
    operand = v;
    push_data = 8'($urandom);
    cin = (o == CCR_OP_ADD) ? 1'b0 : m_psw[7];
    if (o == CCR_OP_ADD || o == CCR_OP_SUM_CARRY_OP) begin
      s = {1'b0, m_acc} + {1'b0, v} + 9'(cin);
      t = {1'b0, m_acc[6:0]} + {1'b0, v[6:0]} + 8'(cin);
      h = (5'(m_acc[3:0]) + 5'(v[3:0]) + 5'(cin)) > 5'h0f;
    end else begin
      s = {1'b0, m_acc} - {1'b0, v} - 9'(cin);
      t = {1'b0, m_acc[6:0]} - {1'b0, v[6:0]} - 8'(cin);
      h = 5'(m_acc[3:0]) < (5'(v[3:0]) + 5'(cin));
    end
    case (o)
      CCR_OP_ADD, CCR_OP_SUM_CARRY_OP, CCR_OP_BORROW_SUB_OP: begin
        // only add and subtract touch the nibble carry
        m_psw[6] = h;
        m_acc = s[7:0];
        m_psw[7] = s[8];
        m_psw[2] = t[7] ^ s[8];
      end
      CCR_OP_MUL: begin
        p = 16'(m_acc) * 16'(m_b);
        {m_b, m_acc} = p;
        m_psw[7] = 1'b0;
        m_psw[2] = p > 16'h00ff;
      end
      CCR_OP_DIV: begin
        m_psw[7] = 1'b0;
        m_psw[2] = (m_b == 8'h00);
        if (m_b != 8'h00) {m_acc, m_b} = {m_acc / m_b, m_acc % m_b};
      end
      CCR_OP_DA: begin
        s = {1'b0, m_acc};
        if (s[3:0] > 4'h9) s = s + 9'h006;
        if (s > 9'h09f || m_psw[7]) s = s + 9'h060;
        m_psw[7] = m_psw[7] | s[8];
        m_acc = s[7:0];
      end
      CCR_OP_COMPARE_JUMP_OP: m_psw[7] = m_acc < v;
      CCR_OP_PUSH: begin
        m_sp = m_sp + 8'h01;
        rq.push_back({m_sp, push_data});
      end
      CCR_OP_POP: m_sp = m_sp - 8'h01;
      default: ;
    endcase
    chk_all();
  endtask : op_run

  ////////////////////////////////////////////////////////////////////////////////
  // monitor: results are taken once the edge's updates have settled
  always @(posedge clk) begin
    cyc++;
    #5;
    while (notes.size() > 0 && notes[0].due <= cyc) begin
      n = notes.pop_front();
      cmp_reg(n.kind, n.exp, got(n.kind));
    end
    if (ram_wr === 1'b1) begin
      if (rq.size() == 0) cmp_ram(16'hxxxx, {ram_addr, ram_wdata});
      else cmp_ram(rq.pop_front(), {ram_addr, ram_wdata});
    end
    // a hang is cut short well past the expected length of the run
    if (cyc >= 3000) begin
      mismatches++;
      test_done();
    end
  end

  // main sequence
  initial begin
    {rst, sfr_wr, sfr_addr, sfr_wdata, operand, push_data, wreg_sel} = '0;
    rst = 1'b1;
    op = CCR_OP_NONE;
    {m_acc, m_b, m_lo, m_hi, m_psw} = '0;
    m_sp = `CCR_RST_STACK;
    void'($urandom(9));
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    chk_all();
    // first push lands at 08h, then back to back
    op_run(CCR_OP_PUSH, 8'h00);
    op_run(CCR_OP_PUSH, 8'h00);
    op_run(CCR_OP_POP, 8'h00);
    foreach (addrs[i]) rd(addrs[i]);
    // every bank and working register
    for (int b = 0; b < 4; b++) begin
      wr(8'hd0, 8'(b << 3));
      for (int r = 0; r < 8; r++) begin
        @(negedge clk);
        sfr_wr = 1'b0;
        wreg_sel = 3'(r);
        note(7, 16'(8 * b + r));
      end
    end
    // decimal adjust with and without a decimal carry
    wr(8'hd0, 8'h00);
    wr(8'he0, 8'h99);
    op_run(CCR_OP_ADD, 8'h01);
    op_run(CCR_OP_DA, 8'h00);
    wr(8'he0, 8'h45);
    op_run(CCR_OP_ADD, 8'h33);
    op_run(CCR_OP_DA, 8'h00);
    // divide by zero keeps both operands
    wr(8'hf0, 8'h00);
    op_run(CCR_OP_DIV, 8'h00);
    // random operands, flags and status writes with a random parity bit
    repeat (80) begin
      wr(8'he0, 8'($urandom));
      wr(8'hf0, 8'($urandom));
      wr(8'hd0, 8'($urandom));
      op_run(arith[$urandom % 6], 8'($urandom));
      rd(addrs[$urandom % 7]);
    end
    @(negedge clk);
    sfr_wr = 1'b0;
    op = CCR_OP_NONE;
    repeat (3) @(negedge clk);
    test_done();
  end
endmodule : tb_cpu_core_regs_and_flags
